// ### status_word_params.svh
// Purpose: constants for the module status word reporter
// Assumes: sys_clk at 250 MHz
// Notes:   bit positions, codes, ranges and timing counts
// Behaviour
// RULE1 - set acknowledge bit 15 on responding; clear when host drops transmit bit
// RULE2 - refuse new commands while acknowledge is high; host waits for zero
// RULE3 - toggle heartbeat bit 14 every 50 ms, a 10 Hz square wave
// RULE4 - bit 13 reads zero as reference master, one as follower
// RULE5 - bit 12 set after power-on tests and reset; cleared by first valid command
// RULE6 - bit 11 high only in calibration mode
// RULE7 - bit 10 high only in configuration mode
// RULE8 - bit 9 high only in setup mode
// RULE9 - bit 8 high only in alignment mode
// RULE10 - bit 7 high only in measurement mode
// RULE11 - bits 6, 5 and 4 always read zero
// RULE12 - bits 3 to 0 carry the programming error code, zero is none
// RULE13 - code 1 for malformed, disallowed, bad password or repeated command
// RULE14 - code 1 for save-parameters command 16#800E while command error shown
// RULE15 - code 1 for single-turn setup with no channel selected
// RULE16 - code 1 for preset on bad channel or channel 2 use in dual mode
// RULE17 - code 1 for dual alignment while single-configured or any channel faulted
// RULE18 - code 1 for save-offset bit without any apply-preset bit
// RULE19 - code 2 on flash save failure, both indicators red, held until power cycle
// RULE20 - code 3 when reference voltage outside 800 to 12000 mV
// RULE21 - code 4 when reference frequency outside 400 to 10000 Hz
// RULE22 - code 5 when winding ratio outside 10 to 300 hundredths
// RULE23 - status word format and position fixed at input word 0 in every mode
// RULE24 - codes 12 to 15 reserved, never reported
// RULE25 - error code held until the next evaluated command replaces it
// RULE26 - exactly one mode flag asserted once self tests finish
`ifndef STATUS_WORD_PARAMS_SVH
`define STATUS_WORD_PARAMS_SVH
`define ACK_BIT         15
`define BEAT_BIT        14
`define FOLLOW_BIT      13
`define INIT_BIT        12
`define CAL_BIT         11
`define CFG_BIT         10
`define SETUP_BIT       9
`define ALIGN_BIT       8
`define MEAS_BIT        7
`define STATUS_WORD_IDX 0
`define STATUS_RESET    16'h0000
`define CMD_SAVE_PARAMS 16'h800E
`define CODE_NONE       4'h0
`define CODE_CMD        4'h1
`define CODE_PERSIST    4'h2
`define CODE_REFV       4'h3
`define CODE_REFF       4'h4
`define CODE_RATIO      4'h5
`define CODE_MAX        4'hB
`define REFV_MIN        16'h0320
`define REFV_MAX        16'h2EE0
`define REFF_MIN        16'h0190
`define REFF_MAX        16'h2710
`define RATIO_MIN       16'h000A
`define RATIO_MAX       16'h012C
`define CLK_MHZ         250
`define BEAT_MS         50
`define BEAT_CYCLES     (`BEAT_MS * 1000 * `CLK_MHZ)
`endif

// ### status_word_pkg.sv
// Purpose: types for the module status word reporter
// Assumes: nothing
// Notes:   no constants here, see the params header
`default_nettype none
package status_word_pkg;
  typedef enum logic [2:0] {
    MODE_CAL   = 3'h0,
    MODE_CFG   = 3'h1,
    MODE_SETUP = 3'h2,
    MODE_ALIGN = 3'h3,
    MODE_MEAS  = 3'h4
  } mode_e;

  typedef struct packed {
    logic        malformed;
    logic        notAllowed;
    logic        badPassword;
    logic        singleTurnNoChan;
    logic        presetBadChan;
    logic        chan2DualUse;
    logic        alignDualSingle;
    logic        alignFaulted;
    logic        offsetNoPreset;
    logic        paramsValid;
    logic [15:0] refVoltMv;
    logic [15:0] refFreqHz;
    logic [15:0] windingRatio;
  } cmd_check_s;
endpackage
`default_nettype wire

// ### status_code_eval.sv
// Purpose: combines the checks of one command into an error code, registered
// Assumes: checks are stable while evalStb is high
// Notes:   priority: command error, then parameter ranges in code order
`include "status_word_params.svh"
`default_nettype none
module status_code_eval (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      evalStb,
  input  wire logic [15:0]               cmdWord,
  input  wire logic                      repeatCmd,
  input  wire logic                      errShown,
  input  wire status_word_pkg::cmd_check_s chk,
  output logic      [3:0]                code_ff
);
  logic [3:0] nxt_code;
  logic       cmdErr;

  always_comb begin
    cmdErr = chk.malformed | chk.notAllowed | chk.badPassword | repeatCmd; // RULE13
    cmdErr = cmdErr | ((cmdWord == `CMD_SAVE_PARAMS) & errShown); // RULE14
    cmdErr = cmdErr | chk.singleTurnNoChan; // RULE15
    cmdErr = cmdErr | chk.presetBadChan | chk.chan2DualUse; // RULE16
    cmdErr = cmdErr | chk.alignDualSingle | chk.alignFaulted; // RULE17
    cmdErr = cmdErr | chk.offsetNoPreset; // RULE18
    nxt_code = `CODE_NONE;
    if (cmdErr) begin
      nxt_code = `CODE_CMD;
    end else if (chk.paramsValid &&
                 (chk.refVoltMv < `REFV_MIN || chk.refVoltMv > `REFV_MAX)) begin
      nxt_code = `CODE_REFV; // RULE20
    end else if (chk.paramsValid &&
                 (chk.refFreqHz < `REFF_MIN || chk.refFreqHz > `REFF_MAX)) begin
      nxt_code = `CODE_REFF; // RULE21
    end else if (chk.paramsValid &&
                 (chk.windingRatio < `RATIO_MIN || chk.windingRatio > `RATIO_MAX)) begin
      nxt_code = `CODE_RATIO; // RULE22
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      code_ff <= `CODE_NONE;
    end else if (evalStb) begin
      code_ff <= nxt_code; // RULE25
    end
  end
endmodule
`default_nettype wire

// ### module_status_word_reporter.sv
// Purpose: builds the 16-bit module state word read as network input word 0
// Assumes: command inputs come from logic on sys_clk; follower strap is a pin
// Notes:   persist failure is sticky until srst, standing in for a power cycle
`include "status_word_params.svh"
`default_nettype none
module module_status_word_reporter #(
  parameter int unsigned BEAT_CYCLES = `BEAT_CYCLES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        selfTestDone,
  input  wire logic                        followerPin,
  input  wire logic                        cmdXmit,
  input  wire logic [15:0]                 cmdWord,
  input  wire status_word_pkg::mode_e      modeReq,
  input  wire logic                        modeReqValid,
  input  wire status_word_pkg::cmd_check_s cmdChk,
  input  wire logic                        persistFail,
  output logic      [15:0]                 moduleStateWord_ff,
  output logic                             cmdAccept_ff,
  output logic                             ledsRed_ff
);
  logic [31:0]                 beatCnt_ff;
  logic                        beat_ff;
  logic [2:0]                  followSync_ff;
  logic                        follower_ff;
  logic                        ack_ff;
  logic                        xmitPrev_ff;
  logic                        init_ff;
  logic                        ready_ff;
  status_word_pkg::mode_e      mode_ff;
  logic [15:0]                 lastCmd_ff;
  logic                        lastOk_ff;
  logic                        persistFail_ff;
  logic                        evalStb;
  logic                        evalStb_ff;
  logic [3:0]                  evalCode;
  logic [3:0]                  codeShown;
  logic                        repeatCmd;
  logic                        cmdOk;
  logic [15:0]                 nxt_word;

  // a new command is the rising transmit bit, seen only with ack low
  assign evalStb   = cmdXmit & ~xmitPrev_ff & ~ack_ff & ready_ff; // RULE2
  assign repeatCmd = lastOk_ff & (cmdWord == lastCmd_ff);

  status_code_eval u_eval (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .evalStb   (evalStb),
    .cmdWord   (cmdWord),
    .repeatCmd (repeatCmd),
    .errShown  (codeShown == `CODE_CMD),
    .chk       (cmdChk),
    .code_ff   (evalCode)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      beatCnt_ff <= 32'h0000_0000;
      beat_ff    <= 1'b0;
    end else if (beatCnt_ff == BEAT_CYCLES - 1) begin
      beatCnt_ff <= 32'h0000_0000;
      beat_ff    <= ~beat_ff; // RULE3
    end else begin
      beatCnt_ff <= beatCnt_ff + 32'h0000_0001;
    end
  end

  // three stages; the first is read only by the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      followSync_ff <= 3'h0;
      follower_ff   <= 1'b0;
    end else begin
      followSync_ff <= {followSync_ff[1:0], followerPin};
      if (followSync_ff[2] == followSync_ff[1]) begin
        follower_ff <= followSync_ff[2]; // RULE4
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      xmitPrev_ff <= 1'b0;
      ack_ff      <= 1'b0;
    end else begin
      xmitPrev_ff <= cmdXmit;
      if (!cmdXmit) begin
        ack_ff <= 1'b0; // RULE1
      end else if (evalStb_ff) begin
        ack_ff <= 1'b1; // RULE1
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      evalStb_ff <= 1'b0;
      cmdOk      <= 1'b0;
    end else begin
      evalStb_ff <= evalStb;
      cmdOk      <= evalStb;
    end
  end

  // acceptance is known one cycle after the strobe, when the code is registered
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ready_ff  <= 1'b0;
      init_ff   <= 1'b0;
      lastCmd_ff <= 16'h0000;
      lastOk_ff <= 1'b0;
    end else begin
      if (selfTestDone && !ready_ff) begin
        ready_ff <= 1'b1;
        init_ff  <= 1'b1; // RULE5
      end else if (cmdOk && evalCode == `CODE_NONE) begin
        init_ff <= 1'b0; // RULE5
      end
      if (evalStb) begin
        lastCmd_ff <= cmdWord;
      end
      if (cmdOk) begin
        lastOk_ff <= (evalCode == `CODE_NONE);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_ff <= status_word_pkg::MODE_MEAS;
    end else if (cmdOk && evalCode == `CODE_NONE && modeReqValid) begin
      case (modeReq)
        status_word_pkg::MODE_CAL,
        status_word_pkg::MODE_CFG,
        status_word_pkg::MODE_SETUP,
        status_word_pkg::MODE_ALIGN,
        status_word_pkg::MODE_MEAS: begin
          mode_ff <= modeReq; // RULE26
        end
        default: begin
          mode_ff <= mode_ff;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      persistFail_ff <= 1'b0;
      ledsRed_ff     <= 1'b0;
    end else if (persistFail) begin
      persistFail_ff <= 1'b1; // RULE19
      ledsRed_ff     <= 1'b1; // RULE19
    end
  end

  // persist failure overrides; reserved codes are clamped out
  always_comb begin
    if (persistFail_ff) begin
      codeShown = `CODE_PERSIST; // RULE19
    end else if (evalCode > `CODE_MAX) begin
      codeShown = `CODE_NONE; // RULE24
    end else begin
      codeShown = evalCode;
    end
  end

  always_comb begin
    nxt_word              = `STATUS_RESET;
    nxt_word[`ACK_BIT]    = ack_ff;
    nxt_word[`BEAT_BIT]   = beat_ff;
    nxt_word[`FOLLOW_BIT] = follower_ff;
    nxt_word[`INIT_BIT]   = init_ff;
    // mode flags only after self tests, so none show during power-up
    nxt_word[`CAL_BIT]    = ready_ff & (mode_ff == status_word_pkg::MODE_CAL); // RULE6
    nxt_word[`CFG_BIT]    = ready_ff & (mode_ff == status_word_pkg::MODE_CFG); // RULE7
    nxt_word[`SETUP_BIT]  = ready_ff & (mode_ff == status_word_pkg::MODE_SETUP); // RULE8
    nxt_word[`ALIGN_BIT]  = ready_ff & (mode_ff == status_word_pkg::MODE_ALIGN); // RULE9
    nxt_word[`MEAS_BIT]   = ready_ff & (mode_ff == status_word_pkg::MODE_MEAS); // RULE10
    nxt_word[6:4]         = 3'h0; // RULE11
    nxt_word[3:0]         = codeShown; // RULE12
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      moduleStateWord_ff <= `STATUS_RESET;
      cmdAccept_ff       <= 1'b0;
    end else begin
      moduleStateWord_ff <= nxt_word; // RULE23
      // a sticky persist failure shows code 2, so nothing counts as accepted then
      cmdAccept_ff       <= cmdOk & (evalCode == `CODE_NONE) & ~persistFail_ff;
    end
  end
endmodule
`default_nettype wire

// ### module_status_word_reporter_sva.sv
// Purpose: port assertions for the status word reporter
// Assumes: one clock domain, srst synchronous
// Notes:   heartbeat period measured by a small counter
`include "status_word_params.svh"
`default_nettype none
module status_word_sva #(
  parameter int unsigned BEAT_CYCLES = 8
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        selfTestDone,
  input wire logic        followerPin,
  input wire logic        cmdXmit,
  input wire logic [15:0] moduleStateWord_ff,
  input wire logic        cmdAccept_ff,
  input wire logic        ledsRed_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [31:0] cnt_ff;
  logic        beatPrev_ff;
  logic        armed_ff;
  logic        initSeen_ff;
  wire logic [15:0] w = moduleStateWord_ff;
  wire logic        beatEdge = w[`BEAT_BIT] != beatPrev_ff;
  always_ff @(posedge sys_clk) beatPrev_ff <= w[`BEAT_BIT];
  // first toggle after reset has no known phase, so only later periods count
  always_ff @(posedge sys_clk) armed_ff <= srst ? 1'b0 : (armed_ff | beatEdge);
  always_ff @(posedge sys_clk) cnt_ff <= (srst | beatEdge) ? 32'h1 : cnt_ff + 32'h1;
  // the init bit drops on the first accepted command, so remember that self tests finished
  always_ff @(posedge sys_clk) initSeen_ff <= srst ? 1'b0 : (initSeen_ff | w[`INIT_BIT]);
  AST_BEAT_PERIOD: assert property (armed_ff && beatEdge |-> cnt_ff == BEAT_CYCLES)
    else $error("heartbeat period wrong");
  AST_BEAT_LATE: assert property (armed_ff |-> cnt_ff <= BEAT_CYCLES)
    else $error("heartbeat stopped");
  AST_ACK_CLEAR: assert property (!cmdXmit ##1 !cmdXmit |=> !w[`ACK_BIT])
    else $error("acknowledge not cleared");
  AST_ACK_CAUSE: assert property ($rose(w[`ACK_BIT]) |-> $past(cmdXmit, 3))
    else $error("acknowledge without command");
  AST_ACCEPT_EDGE: assert property (cmdAccept_ff |-> $past(cmdXmit, 2) && !$past(cmdXmit, 3))
    else $error("accept without fresh transmit");
  AST_ACCEPT_CODE: assert property (cmdAccept_ff |-> w[3:0] == `CODE_NONE ##1 w[`ACK_BIT])
    else $error("accept with error code");
  AST_RESERVED: assert property (w[6:4] == 3'h0)
    else $error("reserved bits set");
  AST_CODE_RANGE: assert property (w[3:0] <= `CODE_MAX)
    else $error("reserved error code");
  AST_ONE_MODE: assert property (initSeen_ff |-> $onehot(w[11:7]))
    else $error("mode flags not one-hot");
  AST_INIT_CLEAR: assert property (cmdAccept_ff |=> !w[`INIT_BIT])
    else $error("init bit kept after accepted command");
  AST_FOLLOW: assert property ((selfTestDone && $stable(followerPin))[*6] |-> w[13] == followerPin)
    else $error("follower bit wrong");
  AST_LEDS: assert property (ledsRed_ff |-> ##2 ledsRed_ff && w[3:0] == `CODE_PERSIST)
    else $error("persist failure not held");
  AST_CODE_HOLD: assert property ($changed(w[3:0]) && w[3:0] != `CODE_PERSIST |-> $past(cmdXmit, 2))
    else $error("code changed without command");
  cover property (cmdAccept_ff);
  cover property (ledsRed_ff);
  cover property (armed_ff && beatEdge);
endmodule
bind module_status_word_reporter status_word_sva #(.BEAT_CYCLES(BEAT_CYCLES)) i_status_word_sva (
  .sys_clk(sys_clk), .srst(srst), .selfTestDone(selfTestDone), .followerPin(followerPin),
  .cmdXmit(cmdXmit), .moduleStateWord_ff(moduleStateWord_ff), .cmdAccept_ff(cmdAccept_ff),
  .ledsRed_ff(ledsRed_ff));
`default_nettype wire

// ### host_cmd_model.sv
// Purpose: host side of the command handshake
// Assumes: one request at a time
// Notes:   slow mode holds transmit a few cycles past acknowledge
`default_nettype none
module host_cmd_model (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        reqStb,
  input  wire logic [15:0] reqWord,
  input  wire logic        slow,
  input  wire logic [15:0] stateWord,
  output logic             cmdXmit,
  output logic [15:0]      cmdWord,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lag_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmdXmit <= 1'b0;
      busy <= 1'b0;
      cmdWord <= 16'h0000;
      lag_ff <= 3'h0;
    end else if (reqStb && !busy) begin
      cmdXmit <= 1'b1;
      cmdWord <= reqWord;
      busy <= 1'b1;
      lag_ff <= slow ? 3'h4 : 3'h0;
    end else if (cmdXmit && stateWord[15] && lag_ff != 3'h0) begin
      lag_ff <= lag_ff - 3'h1;
    end else if (cmdXmit && stateWord[15]) begin
      cmdXmit <= 1'b0;
      cmdWord <= ~cmdWord;
    end else if (!cmdXmit && !stateWord[15]) begin
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### test_module_status_word_reporter.sv
// Purpose: self-checking bench for the status word reporter
// Assumes: heartbeat shortened to 8 cycles
// Notes:   commands go through host_cmd_model
`include "status_word_params.svh"
`default_nettype none
module test_module_status_word_reporter;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] v, f, r; logic [3:0] e;} row_s;
  logic sys_clk = 1'b0, srst = 1'b1, selfTestDone = 1'b0, followerPin = 1'b0;
  logic modeReqValid = 1'b0, persistFail = 1'b0, reqStb = 1'b0, slow = 1'b0;
  logic cmdXmit, busy, cmdAccept_ff, ledsRed_ff;
  logic [15:0] reqWord = 16'h0000, cmdWord, word;
  status_word_pkg::mode_e modeReq = status_word_pkg::MODE_MEAS;
  status_word_pkg::cmd_check_s chk = '0, ok, c;
  int badCount = 0, nTests = 0, accCount = 0, n;
  logic beat;
  row_s rows[9] = '{'{16'h031F, 16'h03E8, 16'h0064, 4'h3}, '{16'h2EE0, 16'h03E8, 16'h0064, 4'h0},
    '{16'h2EE1, 16'h03E8, 16'h0064, 4'h3}, '{16'h0320, 16'h018F, 16'h0064, 4'h4},
    '{16'h0320, 16'h2710, 16'h012C, 4'h0}, '{16'h0320, 16'h2711, 16'h0064, 4'h4},
    '{16'h0320, 16'h0190, 16'h0009, 4'h5}, '{16'h0320, 16'h03E8, 16'h012D, 4'h5},
    '{16'h2EE1, 16'h2711, 16'h012D, 4'h3}};
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cmdAccept_ff === 1'b1) accCount++;
  module_status_word_reporter #(.BEAT_CYCLES(8)) i_module_status_word_reporter (
    .sys_clk(sys_clk), .srst(srst), .selfTestDone(selfTestDone), .followerPin(followerPin),
    .cmdXmit(cmdXmit), .cmdWord(cmdWord), .modeReq(modeReq), .modeReqValid(modeReqValid),
    .cmdChk(chk), .persistFail(persistFail), .moduleStateWord_ff(word),
    .cmdAccept_ff(cmdAccept_ff), .ledsRed_ff(ledsRed_ff));
  host_cmd_model i_host_cmd_model (.sys_clk(sys_clk), .srst(srst), .reqStb(reqStb),
    .reqWord(reqWord), .slow(slow), .stateWord(word), .cmdXmit(cmdXmit), .cmdWord(cmdWord),
    .busy(busy));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // waits on the host model for at most 60 cycles, so a lost acknowledge ends in a busy mismatch
  task automatic send(input logic [15:0] w, input status_word_pkg::cmd_check_s cc,
                      input logic [3:0] exp);
    int a;
    a = accCount;
    chk <= cc;
    reqWord <= w;
    reqStb <= 1'b1;
    tick(1);
    reqStb <= 1'b0;
    tick(2);
    for (int i = 0; i < 60 && busy; i++) tick(1);
    check(16'(busy), 16'h0000);
    check(16'(word[3:0]), 16'(exp));
    check(16'(accCount - a), 16'(exp == `CODE_NONE));
  endtask
  initial begin
    tick(6);
    srst <= 1'b0;
    tick(2);
    check(word & 16'hBFFF, `STATUS_RESET);
    selfTestDone <= 1'b1;
    tick(4);
    check(word & 16'hBFFF, 16'h1080);
    beat = word[`BEAT_BIT];
    for (n = 0; n < 20 && word[`BEAT_BIT] === beat; n++) tick(1);
    beat = word[`BEAT_BIT];
    for (n = 0; n < 20 && word[`BEAT_BIT] === beat; n++) tick(1);
    check(16'(n), 16'h0008);
    ok = '0;
    ok.paramsValid = 1'b1;
    ok.refVoltMv = 16'h03E8;
    ok.refFreqHz = 16'h03E8;
    ok.windingRatio = 16'h0064;
    send(16'h0001, ok, `CODE_NONE);
    check(16'(word[`INIT_BIT]), 16'h0000);
    foreach (rows[i]) begin
      c = ok;
      c.refVoltMv = rows[i].v;
      c.refFreqHz = rows[i].f;
      c.windingRatio = rows[i].r;
      send(16'h0200 + 16'(i), c, rows[i].e);
    end
    modeReqValid <= 1'b1;
    slow <= 1'b1;
    for (int m = 0; m < 5; m++) begin
      modeReq <= status_word_pkg::mode_e'(m);
      send(16'h0010 + 16'(m), ok, `CODE_NONE);
      check(16'(word[11:7]), 16'(5'h10 >> m));
    end
    modeReqValid <= 1'b0;
    slow <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      c = ok;
      c[57 - k] = 1'b1;
      send(16'h0100 + 16'(k), c, `CODE_CMD);
    end
    send(`CMD_SAVE_PARAMS, ok, `CODE_CMD);
    send(16'h0002, ok, `CODE_NONE);
    send(`CMD_SAVE_PARAMS, ok, `CODE_NONE);
    send(`CMD_SAVE_PARAMS, ok, `CODE_CMD);
    followerPin <= 1'b1;
    tick(8);
    check(16'(word[13]), 16'h0001);
    persistFail <= 1'b1;
    tick(1);
    persistFail <= 1'b0;
    tick(6);
    check(16'({ledsRed_ff, word[3:0]}), 16'h0012);
    send(16'h0300, ok, `CODE_PERSIST);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(6);
    check(word & 16'hBFFF, 16'h3080);
    check(16'(ledsRed_ff), 16'h0000);
    tally_and_finish();
  end
  initial begin
    #100000;
    badCount++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
